// [core/lwsp_burst_ctr.sv]
// two-bit burst address generator, linear or interleaved order
// assumes load and advance are already gated by clock hold and sleep
`timescale 1ns/10ps
`include "lwsp_cfg.svh"
module lwsp_burst_ctr (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  lwsp_burst_if.ctr bus
);
  lwsp_pkg::lwsp_burst_state_t st_q;
  lwsp_pkg::lwsp_burst_state_t st_d;
  logic [`LWSP_BURST_W-1:0] step;

  always_comb begin
    st_d = st_q;
    step = st_q.count + `LWSP_BURST_W'(1);
    // wraps after four addresses by width alone
    if (bus.interleave) begin
      bus.next_lsb = st_q.base ^ step;
    end else begin
      bus.next_lsb = st_q.base + step;
    end
    if (bus.load) begin
      st_d.base = bus.preset;
      st_d.count = '0;
    end else if (bus.advance) begin
      st_d.count = step;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule // lwsp_burst_ctr

// [core/lwsp_burst_if.sv]
// control and result signals between the port and its burst counter
// assumes both ends run on the same core clock
`timescale 1ns/10ps
`include "lwsp_cfg.svh"
interface lwsp_burst_if;
  logic load;
  logic advance;
  logic interleave;
  logic [`LWSP_BURST_W-1:0] preset;
  logic [`LWSP_BURST_W-1:0] next_lsb;
  modport ctl (output load, output advance, output interleave, output preset, input next_lsb);
  modport ctr (input load, input advance, input interleave, input preset, output next_lsb);
endinterface

// [core/lwsp_cfg.svh]
// constants for the late-write synchronous memory port
// assumes a single rising-edge core clock; included by the package and modules
`ifndef LWSP_CFG_SVH
`define LWSP_CFG_SVH
`define LWSP_ADDR_W 20
`define LWSP_LANES 4
`define LWSP_LANE_W 9
`define LWSP_DATA_W 36
`define LWSP_BURST_W 2
`define LWSP_SLEEP_CYCLES 2'h2
`define LWSP_SLEEP_CNT_W 2
`endif

// [core/lwsp_dummy_unused.sv]
// spare file with no logic; the port is lwsp_port and its burst counter
// assumes nothing of its surroundings

// [core/lwsp_pkg.sv]
// types shared by the memory port and its burst counter
// assumes lwsp_cfg.svh defines the widths
`include "lwsp_cfg.svh"
package lwsp_pkg;
  typedef enum logic [2:0] {
    LWSP_OP_DESEL = 3'h1,
    LWSP_OP_READ = 3'h2,
    LWSP_OP_WRITE = 3'h4
  } lwsp_op_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`LWSP_ADDR_W-1:0] addr;
    logic [`LWSP_LANES-1:0] lanes;
  } lwsp_stage_t;

  typedef struct packed {
    lwsp_op_t op;
    logic [`LWSP_ADDR_W-1:0] addr;
    lwsp_stage_t s1;
    lwsp_stage_t s2;
    logic [`LWSP_DATA_W-1:0] dout;
    logic drive;
    logic [`LWSP_SLEEP_CNT_W-1:0] sleep_cnt;
    logic asleep;
  } lwsp_state_t;

  typedef struct packed {
    logic [`LWSP_BURST_W-1:0] base;
    logic [`LWSP_BURST_W-1:0] count;
  } lwsp_burst_state_t;
endpackage

// [core/lwsp_port.sv]
// synchronous late-write static memory: command decode, pipelines, array
// assumes all pins except output enable and reset are synchronous to i_core_clk
`timescale 1ns/10ps
`include "lwsp_cfg.svh"
module lwsp_port (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clock_en_n,
  input wire logic i_write_n,
  input wire logic i_load_or_advance,
  input wire logic i_chip_sel_one_n,
  input wire logic i_chip_sel_two,
  input wire logic i_chip_sel_three_n,
  input wire logic i_lane_strobe_a_n,
  input wire logic i_lane_strobe_b_n,
  input wire logic i_lane_strobe_c_n,
  input wire logic i_lane_strobe_d_n,
  input wire logic [`LWSP_ADDR_W-1:0] i_addr,
  input wire logic i_out_en_n,
  input wire logic i_flowthru_select_n,
  input wire logic i_linear_order_n,
  input wire logic i_sleep_request,
  input wire logic [`LWSP_LANE_W-1:0] i_lane_a_io,
  input wire logic [`LWSP_LANE_W-1:0] i_lane_b_io,
  input wire logic [`LWSP_LANE_W-1:0] i_lane_c_io,
  input wire logic [`LWSP_LANE_W-1:0] i_lane_d_io,
  output logic [`LWSP_LANE_W-1:0] o_lane_a_io,
  output logic [`LWSP_LANE_W-1:0] o_lane_b_io,
  output logic [`LWSP_LANE_W-1:0] o_lane_c_io,
  output logic [`LWSP_LANE_W-1:0] o_lane_d_io,
  output logic o_lane_a_io_oe,
  output logic o_lane_b_io_oe,
  output logic o_lane_c_io_oe,
  output logic o_lane_d_io_oe,
  output logic o_asleep
);
  localparam int unsigned WORDS = 1 << `LWSP_ADDR_W;

  logic [1:0] rst_sync_q;
  logic rst_n;
  lwsp_pkg::lwsp_state_t st_q;
  lwsp_pkg::lwsp_state_t st_d;
  logic [`LWSP_DATA_W-1:0] mem [WORDS];
  logic [`LWSP_DATA_W-1:0] din;
  logic selected;
  logic run;
  logic flow;
  logic [`LWSP_ADDR_W-1:0] cur_addr;
  logic [`LWSP_LANES-1:0] cur_lanes;
  logic wr_en;
  logic [`LWSP_ADDR_W-1:0] wr_addr;
  logic [`LWSP_LANES-1:0] wr_lanes;
  logic out_gate;

  lwsp_burst_if burst ();

  lwsp_burst_ctr u_burst (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .bus(burst.ctr)
  );

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign din = {i_lane_d_io, i_lane_c_io, i_lane_b_io, i_lane_a_io};
  assign cur_lanes = ~{i_lane_strobe_d_n, i_lane_strobe_c_n, i_lane_strobe_b_n, i_lane_strobe_a_n};
  assign selected = !i_chip_sel_one_n && i_chip_sel_two && !i_chip_sel_three_n;
  assign flow = !i_flowthru_select_n;
  assign run = !i_clock_en_n && !st_q.asleep;

  // burst counter steps only on cycles that really run
  assign burst.load = run && !i_load_or_advance;
  assign burst.advance = run && i_load_or_advance && (st_q.op != lwsp_pkg::LWSP_OP_DESEL);
  assign burst.preset = i_addr[`LWSP_BURST_W-1:0];
  assign burst.interleave = i_linear_order_n;

  always_comb begin
    st_d = st_q;
    wr_en = 1'b0;
    wr_addr = st_q.s2.addr;
    wr_lanes = st_q.s2.lanes;
    // continue cycles swap in the counter's low bits
    cur_addr = st_q.addr;
    if (i_load_or_advance) begin
      cur_addr[`LWSP_BURST_W-1:0] = burst.next_lsb;
    end else begin
      cur_addr = i_addr;
    end

    // sleep only counts its own input, so it acts during clock hold too
    if (i_sleep_request) begin
      if (st_q.sleep_cnt == `LWSP_SLEEP_CYCLES) begin
        st_d.asleep = 1'b1;
      end else begin
        st_d.sleep_cnt = st_q.sleep_cnt + `LWSP_SLEEP_CNT_W'(1);
      end
    end else begin
      st_d.sleep_cnt = '0;
      st_d.asleep = 1'b0;
    end

    if (run) begin
      // command decode
      if (!i_load_or_advance) begin
        if (!selected) begin
          st_d.op = lwsp_pkg::LWSP_OP_DESEL;
        end else if (i_write_n) begin
          st_d.op = lwsp_pkg::LWSP_OP_READ;
        end else begin
          st_d.op = lwsp_pkg::LWSP_OP_WRITE;
        end
      end
      st_d.addr = cur_addr;
      st_d.s1.valid = (st_d.op != lwsp_pkg::LWSP_OP_DESEL);
      st_d.s1.write = (st_d.op == lwsp_pkg::LWSP_OP_WRITE);
      st_d.s1.addr = cur_addr;
      st_d.s1.lanes = cur_lanes;
      st_d.s2 = st_q.s1;

      if (flow) begin
        // flow-through: array read straight off the captured address
        st_d.drive = st_d.s1.valid && !st_d.s1.write;
        if (st_d.drive) begin
          st_d.dout = mem[cur_addr];
        end
        // single late write, data at second edge
        wr_en = st_q.s1.valid && st_q.s1.write;
        wr_addr = st_q.s1.addr;
        wr_lanes = st_q.s1.lanes;
      end else begin
        // pipelined: output register loads one edge after the command
        st_d.drive = st_q.s1.valid && !st_q.s1.write;
        if (st_d.drive) begin
          st_d.dout = mem[st_q.s1.addr];
        end
        // double late write, data at third edge
        wr_en = st_q.s2.valid && st_q.s2.write;
      end
    end
    if (st_d.asleep) begin
      st_d.drive = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{op: lwsp_pkg::LWSP_OP_DESEL, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge i_core_clk) begin
    if (wr_en) begin
      for (int l = 0; l < `LWSP_LANES; l++) begin
        if (wr_lanes[l]) begin
          mem[wr_addr][l*`LWSP_LANE_W +: `LWSP_LANE_W] <= din[l*`LWSP_LANE_W +: `LWSP_LANE_W];
        end
      end
    end
  end

  // output enable must act without the clock, so it gates the flop here
  assign out_gate = st_q.drive && !i_out_en_n;
  assign o_lane_a_io_oe = out_gate;
  assign o_lane_b_io_oe = out_gate;
  assign o_lane_c_io_oe = out_gate;
  assign o_lane_d_io_oe = out_gate;
  assign {o_lane_d_io, o_lane_c_io, o_lane_b_io, o_lane_a_io} = st_q.dout;
  assign o_asleep = st_q.asleep;
endmodule // lwsp_port

// [verif/lwsp_ctl_model.sv]
// controller model: commands and late write data
// assumes i_pipe matches the port's mode pin
`timescale 1ns/10ps
module lwsp_ctl_model (
  input wire logic i_clk,
  input wire logic i_pipe,
  output logic o_ce_n,
  output logic o_wr_n,
  output logic o_ld,
  output logic [2:0] o_cs,
  output logic [3:0] o_st_n,
  output logic [19:0] o_ad,
  output logic [35:0] o_dat
);
  logic [35:0] wd, sd;
  logic sv;
  // start on hold and deselected so nothing is taken before the first command
  initial begin
    o_ce_n = 1'h1;
    o_wr_n = 1'h1;
    o_ld = 1'h0;
    o_cs = 3'h5;
    o_st_n = 4'hf;
    o_ad = 20'h0;
    o_dat = 36'h0;
    sv = 1'h0;
    wd = 36'h0;
    sd = 36'h0;
  end
  task automatic cmd(input logic w, a, input logic [2:0] m, input logic [3:0] s,
      input logic [19:0] x, input logic [35:0] d);
    @(posedge i_clk);
    {o_ce_n, o_wr_n, o_ld, o_cs, o_st_n, o_ad} <= {1'h0, !w, a, m ^ 3'h5, ~s, x};
    wd <= d;
  endtask
  task automatic hold();
    @(posedge i_clk);
    o_ce_n <= 1'h1;
  endtask
  // released bus flips each cycle that clock enable is low so stale data never passes
  always @(posedge i_clk) if (!o_ce_n) begin
    sv <= !o_wr_n;
    sd <= wd;
    o_dat <= (i_pipe ? sv : !o_wr_n) ? (i_pipe ? sd : wd) : ~o_dat;
  end
endmodule // lwsp_ctl_model

// [verif/lwsp_port_chk.sv]
// pin-level assertions for the memory port
// assumes it is bound to lwsp_port
`timescale 1ns/10ps
`include "lwsp_cfg.svh"
module lwsp_port_chk (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clock_en_n,
  input wire logic i_write_n,
  input wire logic i_load_or_advance,
  input wire logic i_chip_sel_one_n,
  input wire logic i_chip_sel_two,
  input wire logic i_chip_sel_three_n,
  input wire logic i_out_en_n,
  input wire logic i_flowthru_select_n,
  input wire logic i_sleep_request,
  input wire logic [`LWSP_LANE_W-1:0] o_lane_a_io,
  input wire logic o_lane_a_io_oe,
  input wire logic o_lane_d_io_oe,
  input wire logic o_asleep
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire go = !i_clock_en_n && !o_asleep && !i_load_or_advance;
  wire sel = !i_chip_sel_one_n && i_chip_sel_two && !i_chip_sel_three_n;
  wire oe = o_lane_a_io_oe;
  sequence s_rd; go && sel && i_write_n; endsequence
  sequence s_wr; go && sel && !i_write_n; endsequence
  sequence s_ds; go && !sel; endsequence
  sequence s_nx; !i_clock_en_n && i_flowthru_select_n; endsequence
  a_pipe_read: assert property (s_rd ##1 s_nx |=> i_out_en_n || oe)
    else $error("pipelined read not driven");
  a_flow_read: assert property ((s_rd and !i_flowthru_select_n) |=> i_out_en_n || oe)
    else $error("flow read not driven");
  a_pipe_write: assert property (s_wr ##1 s_nx |=> !oe)
    else $error("write drove the bus");
  a_desel_quiet: assert property (s_ds ##1 s_nx |=> !oe)
    else $error("deselect drove the bus");
  a_oe_gate: assert property (i_out_en_n || o_asleep |-> !oe && !o_lane_d_io_oe)
    else $error("drivers on while disabled");
  a_hold_keep: assert property (i_clock_en_n |=> $stable(o_lane_a_io))
    else $error("output moved during hold");
  a_sleep_enter: assert property (i_sleep_request [*3] |=> o_asleep)
    else $error("sleep not entered");
  a_sleep_leave: assert property (!i_sleep_request |=> !o_asleep)
    else $error("sleep not left");
endmodule // lwsp_port_chk
bind lwsp_port lwsp_port_chk u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_clock_en_n(i_clock_en_n), .i_write_n(i_write_n), .i_load_or_advance(i_load_or_advance),
  .i_chip_sel_one_n(i_chip_sel_one_n), .i_chip_sel_two(i_chip_sel_two),
  .i_chip_sel_three_n(i_chip_sel_three_n), .i_out_en_n(i_out_en_n),
  .i_flowthru_select_n(i_flowthru_select_n), .i_sleep_request(i_sleep_request),
  .o_lane_a_io(o_lane_a_io), .o_lane_a_io_oe(o_lane_a_io_oe),
  .o_lane_d_io_oe(o_lane_d_io_oe), .o_asleep(o_asleep));

// [verif/sync_late_write_sram_port_test.sv]
// self-checking bench for the late-write memory port
// assumes the controller model drives commands and write data
`timescale 1ns/10ps
module sync_late_write_sram_port_test;
  localparam logic [35:0] P = 36'h5a5a5a5a5;
  localparam logic [35:0] Q = 36'hc3c3c3c3c;
  localparam logic [19:0] B = 20'h00012;
  localparam logic [19:0] C = 20'h00040;
  logic clk = 1'h0, rst_n = 1'h0, oen = 1'h0, pipe = 1'h1, ord = 1'h0, slp = 1'h0;
  logic ce_n, wr_n, ld, asl, rc = 1'h0, c1 = 1'h0, c2 = 1'h0;
  logic [2:0] cs;
  logic [3:0] st_n, oe;
  logic [19:0] ad;
  logic [35:0] dat, q, dq, re, e1, e2;
  int mismatches = 0, comparisons = 0;
  always #2 clk = !clk;
  assign dq = oe[0] ? q : dat;
  lwsp_ctl_model ctl (.i_clk(clk), .i_pipe(pipe), .o_ce_n(ce_n), .o_wr_n(wr_n), .o_ld(ld),
    .o_cs(cs), .o_st_n(st_n), .o_ad(ad), .o_dat(dat));
  lwsp_port DUT (.i_core_clk(clk), .i_reset_n(rst_n), .i_clock_en_n(ce_n), .i_write_n(wr_n),
    .i_load_or_advance(ld), .i_chip_sel_one_n(cs[0]), .i_chip_sel_two(cs[1]),
    .i_chip_sel_three_n(cs[2]), .i_lane_strobe_a_n(st_n[0]), .i_lane_strobe_b_n(st_n[1]),
    .i_lane_strobe_c_n(st_n[2]), .i_lane_strobe_d_n(st_n[3]), .i_addr(ad), .i_out_en_n(oen),
    .i_flowthru_select_n(pipe), .i_linear_order_n(ord), .i_sleep_request(slp),
    .i_lane_a_io(dq[8:0]), .i_lane_b_io(dq[17:9]), .i_lane_c_io(dq[26:18]),
    .i_lane_d_io(dq[35:27]), .o_lane_a_io(q[8:0]), .o_lane_b_io(q[17:9]),
    .o_lane_c_io(q[26:18]), .o_lane_d_io(q[35:27]), .o_lane_a_io_oe(oe[0]),
    .o_lane_b_io_oe(oe[1]), .o_lane_c_io_oe(oe[2]), .o_lane_d_io_oe(oe[3]), .o_asleep(asl));
  task automatic cmp(input string n, input logic [36:0] e, s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic a, input logic [2:0] m, input logic [19:0] x,
      input logic [35:0] d, input logic [3:0] s);
    ctl.cmd(1'h1, a, m, s, x, d);
    rc <= 1'h0;
  endtask
  task automatic rd(input logic a, input logic [19:0] x, input logic [35:0] e);
    ctl.cmd(1'h0, a, 3'h7, 4'h0, x, 36'h0);
    rc <= 1'h1;
    re <= e;
  endtask
  function automatic logic [35:0] mix(input logic [35:0] o, n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[i*9 +: 9] = n[i*9 +: 9];
    return o;
  endfunction
  function automatic logic [19:0] ba(input int k);
    return {B[19:2], ord ? B[1:0] ^ 2'(k) : B[1:0] + 2'(k)};
  endfunction
  function automatic logic [35:0] dv(input int k);
    return k % 4 ? P + 36'(k) : Q;
  endfunction
  // pipelined answers one running edge later than flow-through
  always @(posedge clk) if (!ce_n) begin
    c2 = c1;
    e2 = e1;
    c1 = rc;
    e1 = re;
    #1 if (pipe ? c2 : c1) cmp("read", {1'h1, pipe ? e2 : e1}, {oe === {4{!oen}}, q});
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // tests take under a hundred cycles; far more means a hang
  initial begin
    #40000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    for (int m = 0; m < 2; m++) begin
      pipe <= m == 0;
      ord <= m == 1;
      oen <= 1'h0;
      repeat (4) wr(1'h0, 3'h0, 20'h0, 36'h0, 4'h0);
      for (int k = 0; k < 5; k++) begin
        wr(k > 0, 3'h7, k ? 20'hfffff : B, dv(k), 4'hf);
      end
      for (int k = 1; k < 5; k++) rd(1'h0, ba(k), dv(k));
      for (int k = 0; k < 5; k++) rd(k > 0, k ? 20'hfffff : B, dv(k));
      wr(1'h0, 3'h7, C, P, 4'hf);
      wr(1'h0, 3'h7, C, Q, 4'h2);
      wr(1'h0, 3'h7, C, ~P, 4'h0);
      for (int k = 0; k < 3; k++) wr(1'h0, 3'h7 ^ 3'(1 << k), C, ~Q, 4'hf);
      rd(1'h0, C, mix(P, Q, 4'h2));
      ctl.hold();
      ctl.hold();
      oen <= 1'h1;
      rd(1'h0, B, Q);
      rd(1'h0, ba(1), dv(1));
      // idles drain pipelined reads before the mode pin moves
      repeat (3) wr(1'h0, 3'h0, 20'h0, 36'h0, 4'h0);
      $display("mode %0d done", m);
    end
    slp <= 1'h1;
    repeat (3) @(posedge clk);
    #1 cmp("asleep", 37'h1, {36'h0, asl});
    @(posedge clk) slp <= 1'h0;
    @(posedge clk);
    #1 cmp("awake", 37'h0, {36'h0, asl});
    rd(1'h0, C, mix(P, Q, 4'h2));
    repeat (3) wr(1'h0, 3'h0, 20'h0, 36'h0, 4'h0);
    $display("sleep done");
    close_out();
  end
endmodule // sync_late_write_sram_port_test
